// >>> rtl/isf_pkg.sv
// Package: register map, field positions and bus carriers of the address status flags block
package isf_pkg;
    localparam int unsigned ISF_AW = 12;

    // Register byte addresses
    localparam logic [11:0] OFF_BUS_STATUS_0     = 12'h000;
    localparam logic [11:0] OFF_SERIAL_CONTROL_0 = 12'h004;
    localparam logic [11:0] OFF_OWN_SLAVE_ADDR   = 12'h008;

    // Field positions in bus_status_0
    localparam int unsigned BIT_EXTENSION_CODE = 1;
    localparam int unsigned BIT_ADDRESS_MATCH  = 2;
    localparam int unsigned BIT_DIRECTION      = 3;

    // Field positions in serial_control_0
    localparam int unsigned BIT_SHIFT_OUT      = 0;
    localparam int unsigned BIT_RELEASE        = 6;
    localparam int unsigned BIT_ENABLE         = 7;

    // Reset values
    localparam logic [7:0]  RST_OWN_SLAVE_ADDR = 8'h00;
    localparam logic [31:0] RST_PRDATA         = 32'h0000_0000;

    // Extension code nibbles, last address bit count and bit counter steps
    localparam logic [3:0]  EXT_CODE_LOW       = 4'h0;
    localparam logic [3:0]  EXT_CODE_HIGH      = 4'hF;
    localparam logic [3:0]  ADDR_LAST_BIT      = 4'h7;
    localparam logic [3:0]  BIT_CNT_ONE        = 4'h1;
    localparam logic [3:0]  BIT_CNT_ZERO       = 4'h0;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ISF_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } isf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } isf_apb_rsp_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } isf_pins_t;
endpackage : isf_pkg

// >>> rtl/isf_sync.sv
// Two-stage synchroniser for the serial clock and data pins
`timescale 1ns/100ps
module isf_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } isf_sync_state_t;

    isf_sync_state_t s;
    isf_sync_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
    end

    // Idle bus level is high, so reset to ones avoids a false start after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;
endmodule : isf_sync

// >>> rtl/isf_status.sv
// Address detection status flags with APB register access
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module isf_status
    import isf_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire isf_pkg::isf_apb_req_t apb_req,
    output isf_pkg::isf_apb_rsp_t      apb_rsp,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe
);
    import isf_pkg::*;

    typedef struct packed {
        isf_pins_t   prev;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic        addr_phase;
        logic        extension_code_flag;
        logic        address_match_flag;
        logic        transfer_direction_flag;
        logic        interface_enable;
        logic        shift_out_latch;
        logic [7:0]  own_slave_address;
        logic [31:0] prdata;
    } isf_state_t;

    isf_state_t s;
    isf_state_t next_s;
    isf_pins_t  pins;

    logic       scl_rise;
    logic       start_det;
    logic       stop_det;
    logic       eighth_edge;
    logic [7:0] addr_byte;
    logic       ext_hit;
    logic       match_hit;
    logic       setup_phase;
    logic       wr_access;
    logic       release_wr;
    logic       enable_fall;
    logic       flag_clear;
    logic       addr_known;
    logic [31:0] read_mux;

    isf_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins)
    );

    // Bus conditions seen on the synchronised pins
    assign scl_rise  = pins.scl & ~s.prev.scl;
    assign start_det = s.interface_enable & pins.scl & s.prev.scl & s.prev.sda & ~pins.sda;
    assign stop_det  = s.interface_enable & pins.scl & s.prev.scl & ~s.prev.sda & pins.sda;

    // Only the first byte after a start is treated as an address
    assign eighth_edge = s.interface_enable & s.addr_phase & scl_rise
                         & (s.bit_cnt == ADDR_LAST_BIT);
    assign addr_byte   = {s.shift[6:0], pins.sda};
    assign ext_hit     = (addr_byte[7:4] == EXT_CODE_LOW)
                         | (addr_byte[7:4] == EXT_CODE_HIGH);
    assign match_hit   = (addr_byte[7:1] == s.own_slave_address[7:1]);

    // APB decode; zero wait states, every access completes in its first access cycle
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign wr_access   = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign addr_known  = (apb_req.paddr == OFF_BUS_STATUS_0)
                         | (apb_req.paddr == OFF_SERIAL_CONTROL_0)
                         | (apb_req.paddr == OFF_OWN_SLAVE_ADDR);
    assign release_wr  = wr_access & (apb_req.paddr == OFF_SERIAL_CONTROL_0)
                         & apb_req.pwdata[BIT_RELEASE];
    assign enable_fall = wr_access & (apb_req.paddr == OFF_SERIAL_CONTROL_0)
                         & s.interface_enable & ~apb_req.pwdata[BIT_ENABLE];
    assign flag_clear  = start_det | stop_det | release_wr | enable_fall;

    always_comb begin
        read_mux = RST_PRDATA;
        case (apb_req.paddr)
            OFF_BUS_STATUS_0: begin
                read_mux[BIT_EXTENSION_CODE] = s.extension_code_flag;
                read_mux[BIT_ADDRESS_MATCH]  = s.address_match_flag;
                read_mux[BIT_DIRECTION]      = s.transfer_direction_flag;
            end
            OFF_SERIAL_CONTROL_0: begin
                read_mux[BIT_ENABLE]    = s.interface_enable;
                read_mux[BIT_SHIFT_OUT] = s.shift_out_latch;
            end
            OFF_OWN_SLAVE_ADDR: begin
                read_mux[7:0] = s.own_slave_address;
            end
            default: begin
                read_mux = RST_PRDATA;
            end
        endcase
    end

    always_comb begin
        next_s      = s;
        next_s.prev = pins;

        // Register writes; bus_status_0 has no write path at all
        if (wr_access) begin
            case (apb_req.paddr)
                OFF_SERIAL_CONTROL_0: begin
                    next_s.interface_enable = apb_req.pwdata[BIT_ENABLE];
                    next_s.shift_out_latch  = apb_req.pwdata[BIT_SHIFT_OUT];
                end
                OFF_OWN_SLAVE_ADDR: begin
                    next_s.own_slave_address = apb_req.pwdata[7:0];
                end
                default: begin
                    next_s.own_slave_address = s.own_slave_address;
                end
            endcase
        end
        if (setup_phase) begin
            next_s.prdata = read_mux;
        end

        // Address byte collection
        if (start_det) begin
            next_s.addr_phase = 1'b1;
            next_s.bit_cnt    = BIT_CNT_ZERO;
        end else if (s.addr_phase & scl_rise & s.interface_enable) begin
            next_s.shift   = addr_byte;
            next_s.bit_cnt = s.bit_cnt + BIT_CNT_ONE;
            if (eighth_edge) begin
                next_s.addr_phase = 1'b0;
            end
        end
        if (stop_det | enable_fall) begin
            next_s.addr_phase = 1'b0;
        end

        // Clears first, so a set in the same cycle wins
        if (flag_clear) begin
            next_s.extension_code_flag     = 1'b0;
            next_s.address_match_flag      = 1'b0;
            next_s.transfer_direction_flag = 1'b0;
        end
        if (eighth_edge) begin
            if (ext_hit) begin
                next_s.extension_code_flag = 1'b1;
            end
            if (match_hit) begin
                next_s.address_match_flag      = 1'b1;
                next_s.transfer_direction_flag = addr_byte[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                   <= '0;
            s.prev              <= '1;
            s.own_slave_address <= RST_OWN_SLAVE_ADDR;
            s.prdata            <= RST_PRDATA;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp.prdata  = s.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_known;

    // Receive leaves the line released; transmit drives the latch value
    assign sda_out = s.shift_out_latch;
    assign sda_oe  = s.transfer_direction_flag;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ext_set;
        eighth_edge && ext_hit |=> s.extension_code_flag;
    endproperty
    a_ext_set: assert property (p_ext_set)
        else $error("extension code flag not set on qualifying address");

    property p_ext_rise_cause;
        $rose(s.extension_code_flag) |-> $past(eighth_edge) && $past(ext_hit);
    endproperty
    a_ext_rise_cause: assert property (p_ext_rise_cause)
        else $error("extension code flag rose without a qualifying address");

    property p_ext_clear;
        flag_clear && !eighth_edge |=> !s.extension_code_flag;
    endproperty
    a_ext_clear: assert property (p_ext_clear)
        else $error("extension code flag survived a clear condition");

    property p_match_set;
        eighth_edge && match_hit |=> s.address_match_flag
            && (s.transfer_direction_flag == $past(pins.sda));
    endproperty
    a_match_set: assert property (p_match_set)
        else $error("address match or direction wrong after eighth clock");

    property p_match_clear;
        flag_clear && !eighth_edge |=> !s.address_match_flag && !sda_oe;
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("address match flag survived a clear condition");

    // Transmit status, and so a driven line, only after a matched read address
    property p_line_drive;
        $rose(sda_oe) |-> $past(eighth_edge) && $past(match_hit) && $past(pins.sda);
    endproperty
    a_line_drive: assert property (p_line_drive)
        else $error("data line driven without a matched read address");

    property p_match_rise_cause;
        $rose(s.address_match_flag) |-> $past(eighth_edge) && $past(match_hit);
    endproperty
    a_match_rise_cause: assert property (p_match_rise_cause)
        else $error("address match flag rose without a matching address");

    // A disabled interface must never raise a flag
    property p_disabled_quiet;
        !s.interface_enable
            |=> !$rose(s.extension_code_flag) && !$rose(s.address_match_flag);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("status flag rose while the interface was disabled");

    property p_write_no_effect;
        wr_access && !eighth_edge && !flag_clear
            |=> $stable({s.extension_code_flag, s.address_match_flag,
                         s.transfer_direction_flag});
    endproperty
    a_write_no_effect: assert property (p_write_no_effect)
        else $error("status flags changed by a software write");

    property p_status_read;
        setup_phase && (apb_req.paddr == OFF_BUS_STATUS_0)
            |=> apb_rsp.prdata[BIT_ADDRESS_MATCH] == $past(s.address_match_flag);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show the address match flag");

    c_ext_code: cover property (eighth_edge && ext_hit);
    c_match_tx: cover property (eighth_edge && match_hit && addr_byte[0]);
    c_release:  cover property (release_wr && s.address_match_flag);
    c_stop_clr: cover property (stop_det && (s.extension_code_flag || s.address_match_flag));
    c_en_fall:  cover property (enable_fall && (s.extension_code_flag || s.address_match_flag));
endmodule : isf_status

// >>> test/isf_master_model.sv
// Behavioural serial bus master that addresses the device
`timescale 1ns/100ps
module isf_master_model (
    output logic scl,
    output logic sda
);
    // Clock stands high before the first frame, data released to the pull-up
    initial begin
        scl = 1'h1;
        sda = 1'h1;
    end

    // Odd offset keeps the link edges off the bus clock phase
    task start_cond();
        #1.7;
        sda = 1'h1;
        #20 scl = 1'h1;
        #20 sda = 1'h0;
        #20 scl = 1'h0;
        #20;
    endtask : start_cond

    // Most significant bit first, data settled 20 ns before each rise
    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #20 scl = 1'h1;
            #40 scl = 1'h0;
            #20;
        end
        sda = 1'h1;
    endtask : send_byte

    // Same offset as start, so the first data change never lands on a bus clock edge
    task stop_cond();
        #1.7;
        sda = 1'h0;
        #20 scl = 1'h1;
        #20 sda = 1'h1;
        #40;
    endtask : stop_cond
endmodule : isf_master_model

// >>> test/isf_status_tb.sv
// Self-checking bench for the address status flags block
`timescale 1ns/100ps
module isf_status_tb;
    import isf_pkg::*;
    logic         pclk;
    logic         presetn;
    isf_apb_req_t req;
    isf_apb_rsp_t rsp;
    logic         scl_m;
    logic         sda_m;
    logic         sda_out;
    logic         sda_oe;
    logic         sda_line;
    logic [7:0]   own;
    logic [31:0]  rd;
    logic         err;
    integer       seed;
    int           miscompares;
    int           check_count;
    int           cycles;
    int           exp_ext;
    int           exp_match;
    int           exp_dir;
    int           addr_q[$];

    // Pull-up wire: low whenever either party pulls it low
    assign sda_line = sda_m & ~(sda_oe & ~sda_out);

    isf_status u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .scl_in(scl_m), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
    isf_master_model u_master (.scl(scl_m), .sda(sda_m));

    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Request held from setup until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel    <= 1'h1;
        req.penable <= 1'h0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge pclk);
        req.penable <= 1'h1;
        do @(posedge pclk); while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'h0;
        req.penable <= 1'h0;
    endtask : apb

    function automatic logic [31:0] status_word();
        return 32'(exp_ext * 2 + exp_match * 4 + exp_dir * 8);
    endfunction : status_word

    task frame(input logic [7:0] b);
        u_master.start_cond();
        u_master.send_byte(b);
        exp_ext = (b[7:4] == 4'h0 || b[7:4] == 4'hF);
        exp_match = (b[7:1] == own[7:1]);
        exp_dir = exp_match && b[0];
        apb(1'h0, OFF_BUS_STATUS_0, 32'h0);
        chk("bus_status_0", status_word(), rd);
        chk("sda_oe", 32'(exp_dir), 32'(sda_oe));
        if (exp_dir) chk("sda_out", 32'h1, 32'(sda_out));
    endtask : frame

    task clear_by(input int k);
        case (k)
            0: u_master.stop_cond();
            1: u_master.start_cond();
            2: apb(1'h1, OFF_SERIAL_CONTROL_0, 32'hC1);
            default: begin
                apb(1'h1, OFF_SERIAL_CONTROL_0, 32'h01);
                apb(1'h1, OFF_SERIAL_CONTROL_0, 32'h81);
            end
        endcase
        exp_ext = 0;
        exp_match = 0;
        exp_dir = 0;
        apb(1'h0, OFF_BUS_STATUS_0, 32'h0);
        chk("status cleared", status_word(), rd);
        chk("sda_oe cleared", 32'h0, 32'(sda_oe));
    endtask : clear_by

    initial begin
        presetn = 1'h0;
        req = '0;
        seed = 19;
        cycles = 0;
        miscompares = 0;
        check_count = 0;
        exp_ext = 0;
        exp_match = 0;
        exp_dir = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OFF_BUS_STATUS_0, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'h0, OFF_OWN_SLAVE_ADDR, 32'h0);
        chk("own address reset", 32'h0, rd);
        apb(1'h0, 12'h00C, 32'h0);
        chk("unmapped pslverr", 32'h1, 32'(err));
        chk("unmapped rdata", 32'h0, rd);
        own = 8'($random(seed));
        own[0] = 1'h0;
        apb(1'h1, OFF_OWN_SLAVE_ADDR, {24'h0, own});
        // Latch kept at 1 so a driven data line never blocks start or stop
        apb(1'h1, OFF_SERIAL_CONTROL_0, 32'h81);
        addr_q = {own, own | 8'h01, 8'h0A, 8'hF7, 8'h10, 8'hEF, $random(seed)};
        for (int i = 0; i < addr_q.size(); i++) begin
            frame(8'(addr_q[i]));
            apb(1'h1, OFF_BUS_STATUS_0, ~status_word());
            apb(1'h0, OFF_BUS_STATUS_0, 32'h0);
            chk("status after write", status_word(), rd);
            clear_by(i % 4);
        end
        // Mid-run reset with the match and direction flags set
        frame(own | 8'h01);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        exp_ext = 0;
        exp_match = 0;
        exp_dir = 0;
        apb(1'h0, OFF_BUS_STATUS_0, 32'h0);
        chk("status after reset", status_word(), rd);
        chk("sda_oe after reset", 32'h0, 32'(sda_oe));
        end_of_test();
    end
endmodule : isf_status_tb
